// file: tb/alarm_led_ack_and_text_display_bench.sv
// self-checking bench for the alarm indicator and alarm text block
`timescale 1ns/10ps
`include "aled_cfg.svh"
module alarm_led_ack_and_text_display_bench;
	localparam int IDLE = 200;
	localparam int HOLD = 20;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic key_info_n, key_next_n, key_clear_n;
	logic [3:0] alarm_in = 4'h0;
	logic [3:0] led_ff, alarm_reset_ff;
	logic disp_open_ff, text_active_ff, disp_err_ff, irq_ff;
	logic [1:0] text_sel_ff, s_axi_bresp, s_axi_rresp;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	int failures = 0;
	int check_count = 0;
	int pulses = 0;
	int n;

	always #20 clk = ~clk;
	// count acknowledgment pulses that withdraw an output action
	always @(posedge clk) if (|alarm_reset_ff) pulses++;

	aled_top #(.IDLE_CYC(IDLE), .HOLD_CYC(HOLD), .FAST_HALF(4),
		.SLOW_HALF(16)) dut_u (
		.clk(clk), .resetn(resetn), .key_info_n(key_info_n),
		.key_next_n(key_next_n), .key_clear_n(key_clear_n),
		.alarm_in(alarm_in), .led_ff(led_ff), .disp_open_ff(disp_open_ff),
		.text_sel_ff(text_sel_ff), .text_active_ff(text_active_ff),
		.disp_err_ff(disp_err_ff), .alarm_reset_ff(alarm_reset_ff),
		.irq_ff(irq_ff), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);
	aled_operator op_u (.clk(clk), .key_info_n(key_info_n),
		.key_next_n(key_next_n), .key_clear_n(key_clear_n));

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid) && k < 50);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask
	// bus read: data kept in rdv for the caller to compare
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && !s_axi_arvalid) && k < 50);
		s_axi_rready <= 1'b0;
		rdv = s_axi_rdata;
		chk("rresp", er, s_axi_rresp);
	endtask
	// count changes of one indicator over 32 cycles; level checked if steady
	// a short settle first, so the latch set-up edges are not counted
	task automatic flash(input int i, input int exp, input logic lvl);
		int t;
		logic p;
		t = 0;
		repeat (3) @(negedge clk);
		@(negedge clk);
		p = led_ff[i];
		repeat (32) begin
			@(negedge clk);
			if (led_ff[i] !== p) t++;
			p = led_ff[i];
		end
		chk("led toggles", exp, t);
		if (exp == 0) chk("led level", lvl, led_ff[i]);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`ALED_OFS_CTRL, 2'h0);
		chk("ctrl", `ALED_CTRL_RST, rdv);
		rd(`ALED_OFS_IEN, 2'h0);
		chk("ien", `ALED_IEN_RST, rdv);
		rd(8'h40, 2'h3);
		wr(8'h40, 32'h0, 2'h3);
		$display("test registers done");
		// no function configured: opening only flags an error
		wr(`ALED_OFS_CTRL, 32'h01, 2'h0);
		wr(`ALED_OFS_ICLR, 32'hf, 2'h0);
		op_u.push(0, 4);
		chk("open", 0, disp_open_ff);
		rd(`ALED_OFS_ISTS, 2'h0);
		chk("err event", 32'h4, rdv & 32'h4);
		$display("test empty list done");
		// new alarm flashes fast; its event is masked, then enabled, cleared
		wr(`ALED_OFS_CTRL, 32'hf3, 2'h0);
		alarm_in <= 4'h4;
		flash(2, 8, 0);
		chk("irq masked", 0, irq_ff);
		wr(`ALED_OFS_IEN, 32'h1, 2'h0);
		repeat (2) @(negedge clk);
		chk("irq", 1, irq_ff);
		wr(`ALED_OFS_ICLR, 32'h1, 2'h0);
		repeat (2) @(negedge clk);
		chk("irq clear", 0, irq_ff);
		$display("test flash and irq done");
		// open on highest priority, acknowledge it, once per hold
		op_u.push(0, 4);
		chk("sel", 2, text_sel_ff);
		chk("text", 1, text_active_ff);
		op_u.push(2, 3 * HOLD);
		chk("pulses", 1, pulses);
		flash(2, 0, 1);
		rd(`ALED_OFS_STAT, 2'h0);
		chk("stat", 32'hd04, rdv);
		@(posedge clk);
		alarm_in <= 4'h6;
		repeat (3) @(posedge clk);
		alarm_in <= 4'h4;
		flash(1, 2, 0);
		for (int i = 0; i < 3; i++) begin
			op_u.push(1, 4);
			chk("sel", (3 + i) % 4, text_sel_ff);
			chk("text", 0, text_active_ff);
		end
		op_u.push(2, 3 * HOLD);
		chk("pulses", 2, pulses);
		flash(1, 0, 0);
		$display("test acknowledge done");
		// idle display closes by itself
		op_u.push(1, 4);
		n = 0;
		while (disp_open_ff === 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("idle close", 1, n > IDLE - 40 && n <= IDLE);
		rd(`ALED_OFS_ISTS, 2'h0);
		chk("timeout event", 32'h8, rdv & 32'h8);
		op_u.push(0, 4);
		chk("open", 1, disp_open_ff);
		op_u.push(0, 4);
		chk("closed", 0, disp_open_ff);
		$display("test close done");
		// without acknowledgment no flashing and holds do nothing
		wr(`ALED_OFS_CTRL, 32'hf2, 2'h0);
		alarm_in <= 4'h5;
		flash(0, 0, 1);
		op_u.push(0, 4);
		op_u.push(2, 3 * HOLD);
		chk("pulses", 2, pulses);
		flash(0, 0, 1);
		wr(`ALED_OFS_CTRL, 32'he2, 2'h0);
		flash(0, 0, 0);
		$display("test no acknowledge done");
		test_done;
	end

	// watchdog for a hung handshake or wait
	initial begin
		repeat (10000) @(posedge clk);
		failures++;
		$display("MISMATCH watchdog expected end seen timeout");
		test_done;
	end
endmodule

// file: tb/aled_operator.sv
// front panel operator model driving the three keys
`timescale 1ns/10ps
module aled_operator (
	// clock
	input wire logic clk,
	// key pins, low while pressed, pulled up when released
	output logic key_info_n,
	output logic key_next_n,
	output logic key_clear_n
);
	logic [2:0] keys_n = 3'h7;
	assign {key_clear_n, key_next_n, key_info_n} = keys_n;
	// press key k (0 info, 1 next, 2 clear) for cyc cycles; the gap after
	// release lets the conditioner report before anything is checked
	task automatic push(input int k, input int cyc);
		@(posedge clk);
		keys_n[k] <= 1'b0;
		repeat (cyc) @(posedge clk);
		keys_n[k] <= 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
	endtask
endmodule

// file: tb/aled_top_monitor.sv
// concurrent checks on the ports of the alarm indicator block
`timescale 1ns/10ps
module aled_top_monitor #(
	parameter int unsigned IDLE_CYC = 200,
	parameter int unsigned HOLD_CYC = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// keys and alarms
	input wire logic key_info_n,
	input wire logic key_next_n,
	input wire logic key_clear_n,
	input wire logic [3:0] alarm_in,
	// display and acknowledgment
	input wire logic disp_open_ff,
	input wire logic [1:0] text_sel_ff,
	input wire logic text_active_ff,
	input wire logic disp_err_ff,
	input wire logic [3:0] alarm_reset_ff,
	// bus handshakes
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// helper counters; the idle count starts late, so it only bounds
	logic [31:0] idle_ff, nxt_idle, info_age_ff, nxt_info_age;
	logic [31:0] clr_len_ff, nxt_clr_len;
	logic clr_low_ff, nxt_clr_low;
	always_comb begin
		nxt_idle = idle_ff + 32'h1;
		if (!key_info_n || !key_next_n || !key_clear_n || !disp_open_ff)
			nxt_idle = 32'h0;
		nxt_info_age = key_info_n ? info_age_ff + 32'h1 : 32'h0;
		nxt_clr_low = !key_clear_n;
		nxt_clr_len = clr_len_ff;
		if (!key_clear_n)
			nxt_clr_len = clr_low_ff ? clr_len_ff + 32'h1 : 32'h1;
	end
	// register the counters
	always_ff @(posedge clk) begin
		if (!resetn) begin
			idle_ff <= 32'h0;
			info_age_ff <= 32'hff;
			clr_len_ff <= 32'h0;
			clr_low_ff <= 1'b0;
		end else begin
			idle_ff <= nxt_idle;
			info_age_ff <= nxt_info_age;
			clr_len_ff <= nxt_clr_len;
			clr_low_ff <= nxt_clr_low;
		end
	end

	property p_err_pulse;
		disp_err_ff |-> !disp_open_ff ##1 !disp_err_ff;
	endproperty
	a_err_pulse: assert property (p_err_pulse)
		else $error("error flag not a lone pulse or display open");
	property p_open_cause;
		disp_err_ff || $rose(disp_open_ff) |-> info_age_ff < 32'd12;
	endproperty
	a_open_cause: assert property (p_open_cause)
		else $error("display opened without an info key press");
	property p_idle_close;
		disp_open_ff |-> idle_ff <= IDLE_CYC + 8;
	endproperty
	a_idle_close: assert property (p_idle_close)
		else $error("display stayed open past the idle time");
	property p_ack_hold;
		alarm_reset_ff != 4'h0 |-> clr_len_ff >= HOLD_CYC;
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("acknowledgment without a long clear hold");
	property p_ack_shown;
		alarm_reset_ff != 4'h0 |-> alarm_reset_ff == (4'h1 << text_sel_ff);
	endproperty
	a_ack_shown: assert property (p_ack_shown)
		else $error("acknowledgment hit an alarm not shown");
	property p_text_match;
		disp_open_ff && $past(disp_open_ff) && $stable(alarm_in)
			&& $stable(text_sel_ff) |-> text_active_ff == alarm_in[text_sel_ff];
	endproperty
	a_text_match: assert property (p_text_match)
		else $error("shown text does not match alarm state");
	property p_bvalid_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped before taken");
	property p_rvalid_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold)
		else $error("read data dropped before taken");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read answer late");
endmodule

bind aled_top aled_top_monitor #(.IDLE_CYC(IDLE_CYC), .HOLD_CYC(HOLD_CYC))
mon_u (
	.clk(clk), .resetn(resetn), .key_info_n(key_info_n),
	.key_next_n(key_next_n), .key_clear_n(key_clear_n),
	.alarm_in(alarm_in), .disp_open_ff(disp_open_ff),
	.text_sel_ff(text_sel_ff), .text_active_ff(text_active_ff),
	.disp_err_ff(disp_err_ff), .alarm_reset_ff(alarm_reset_ff),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp)
);

// file: verilog/aled_cfg.svh
// constants for the alarm indicator and alarm text display block
//
// Notes on behaviour
// - an indicator is dark when its alarm is inactive, steady when active and acknowledged, fast flashing when active and unacknowledged.
// - an alarm that came and went unacknowledged flashes slowly, and acknowledging it turns the indicator dark.
// - without the acknowledgment-required option no indicator ever flashes, only steady or dark.
// - an indicator shows anything only when its logic function is configured, else it stays dark.
// - the alarm text list holds one entry per configured logic function, four at most.
// - opening the alarm display with no function in use gives an error indication and the mode ends at once.
// - each alarm has an active and an inactive text, and the list presents the one matching the present state.
// - the first entry shown on opening is the alarm with the highest priority.
// - a short press of the info key opens the alarm text display and a further key press closes it; here only an info key short press closes it.
// - the alarm text display closes by itself after 30 s without any key press.
// - without the acknowledgment-required option, acknowledgment key actions change no indicator.
// - acknowledgment applies only to the alarm shown and needs the clear key held longer than 2 s.
// - with the reset-by-display option, acknowledging also withdraws the output action of that alarm.
`ifndef ALED_CFG_SVH
`define ALED_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ALED_CLK_HZ 25000000
`define ALED_IDLE_S 30
`define ALED_HOLD_S 2
`define ALED_IDLE_CYC (`ALED_IDLE_S * `ALED_CLK_HZ)
`define ALED_HOLD_CYC (`ALED_HOLD_S * `ALED_CLK_HZ)
`define ALED_FAST_HALF 3125000
`define ALED_SLOW_HALF 12500000

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ALED_OFS_CTRL 8'h00
`define ALED_OFS_STAT 8'h04
`define ALED_OFS_ISTS 8'h08
`define ALED_OFS_ICLR 8'h0c
`define ALED_OFS_IEN 8'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ALED_CTRL_ACKREQ 0
`define ALED_CTRL_RBD 1
`define ALED_CTRL_CFG_LO 4
`define ALED_CTRL_RST 8'hf1
`define ALED_IEN_RST 4'h0
`define ALED_EV_RISE 0
`define ALED_EV_ACK 1
`define ALED_EV_ERR 2
`define ALED_EV_TMO 3

`endif

// file: verilog/aled_flash.sv
// common flash phase generator for all indicators
`timescale 1ns/10ps
`include "aled_cfg.svh"
module aled_flash #(
	parameter int unsigned FAST_HALF = `ALED_FAST_HALF,
	parameter int unsigned SLOW_HALF = `ALED_SLOW_HALF
) (
	// clock and reset
	input logic clk,
	input logic resetn,
	// flash phases
	output logic fast_ff,
	output logic slow_ff
);
	logic [31:0] fcnt_ff, nxt_fcnt, scnt_ff, nxt_scnt;
	logic nxt_fast, nxt_slow;

	// one counter per rate; sharing them keeps every indicator in phase
	always_comb begin
		nxt_fcnt = fcnt_ff + 32'h1;
		nxt_fast = fast_ff;
		nxt_scnt = scnt_ff + 32'h1;
		nxt_slow = slow_ff;
		if (fcnt_ff >= FAST_HALF - 1) begin
			nxt_fcnt = 32'h0;
			nxt_fast = ~fast_ff;
		end
		if (scnt_ff >= SLOW_HALF - 1) begin
			nxt_scnt = 32'h0;
			nxt_slow = ~slow_ff;
		end
	end

	// phase registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fcnt_ff <= 32'h0;
			scnt_ff <= 32'h0;
			fast_ff <= 1'b0;
			slow_ff <= 1'b0;
		end else begin
			fcnt_ff <= nxt_fcnt;
			scnt_ff <= nxt_scnt;
			fast_ff <= nxt_fast;
			slow_ff <= nxt_slow;
		end
	end
endmodule

// file: verilog/aled_key_if.sv
// key events passed from the key conditioner to the display logic
`timescale 1ns/10ps
interface aled_key_if #(parameter int N = 3);
	logic [N-1:0] press;
	logic [N-1:0] short_rel;
	logic [N-1:0] hold;

	modport src (output press, output short_rel, output hold);
	modport dst (input press, input short_rel, input hold);
endinterface

// file: verilog/aled_keys.sv
// key synchroniser, short press and long hold detector
`timescale 1ns/10ps
`include "aled_cfg.svh"
module aled_keys #(
	parameter int N = 3,
	parameter int unsigned HOLD_CYC = `ALED_HOLD_CYC
) (
	// clock and reset
	input logic clk,
	input logic resetn,
	// raw key pins, low while pressed
	input logic [N-1:0] keys_n,
	// events
	aled_key_if.src ev
);
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : gk
			logic s1_ff, s2_ff, prev_ff, fired_ff;
			logic nxt_prev, nxt_fired;
			logic [31:0] cnt_ff, nxt_cnt;
			logic pr_ff, sr_ff, hd_ff, nxt_pr, nxt_sr, nxt_hd;

			// held count runs only while pressed; fired blocks repeats
			always_comb begin
				nxt_prev = s2_ff;
				nxt_cnt = s2_ff ? cnt_ff : 32'h0;
				nxt_fired = s2_ff ? fired_ff : 1'b0;
				nxt_pr = s2_ff & ~prev_ff;
				nxt_sr = ~s2_ff & prev_ff & ~fired_ff;
				nxt_hd = 1'b0;
				if (s2_ff && !fired_ff) begin
					nxt_cnt = cnt_ff + 32'h1;
					if (cnt_ff >= HOLD_CYC) begin
						nxt_hd = 1'b1;
						nxt_fired = 1'b1;
					end
				end
			end

			// two stage synchroniser then event registers
			always_ff @(posedge clk) begin
				if (!resetn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					prev_ff <= 1'b0;
					fired_ff <= 1'b0;
					cnt_ff <= 32'h0;
					pr_ff <= 1'b0;
					sr_ff <= 1'b0;
					hd_ff <= 1'b0;
				end else begin
					s1_ff <= ~keys_n[g];
					s2_ff <= s1_ff;
					prev_ff <= nxt_prev;
					fired_ff <= nxt_fired;
					cnt_ff <= nxt_cnt;
					pr_ff <= nxt_pr;
					sr_ff <= nxt_sr;
					hd_ff <= nxt_hd;
				end
			end

			assign ev.press[g] = pr_ff;
			assign ev.short_rel[g] = sr_ff;
			assign ev.hold[g] = hd_ff;
		end
	endgenerate
endmodule

// file: verilog/aled_pkg.sv
// types shared by the alarm indicator block
package aled_pkg;
	typedef enum logic {
		DS_CLOSED,
		DS_OPEN
	} aled_disp_t;

	typedef enum logic [1:0] {
		KEY_INFO,
		KEY_NEXT,
		KEY_CLEAR
	} aled_key_t;

	typedef enum logic [1:0] {
		RSEL_CTRL,
		RSEL_STAT,
		RSEL_ISTS,
		RSEL_OTHER
	} aled_rsel_t;
endpackage

// file: verilog/aled_top.sv
// alarm indicators, alarm text list and acknowledgment with axi4-lite access
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "aled_cfg.svh"
module aled_top
	import aled_pkg::*;
#(
	parameter int unsigned IDLE_CYC = `ALED_IDLE_CYC,
	parameter int unsigned HOLD_CYC = `ALED_HOLD_CYC,
	parameter int unsigned FAST_HALF = `ALED_FAST_HALF,
	parameter int unsigned SLOW_HALF = `ALED_SLOW_HALF
) (
	// clock and reset
	input logic clk,
	input logic resetn,
	// front panel keys, low while pressed: info, next, clear
	input logic key_info_n,
	input logic key_next_n,
	input logic key_clear_n,
	// alarm states from the logic module
	input logic [3:0] alarm_in,
	// indicators and text selection
	output logic [3:0] led_ff,
	output logic disp_open_ff,
	output logic [1:0] text_sel_ff,
	output logic text_active_ff,
	output logic disp_err_ff,
	output logic [3:0] alarm_reset_ff,
	// interrupt
	output logic irq_ff,
	// axi4-lite slave
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// register decode shared by read and write paths
	function automatic aled_rsel_t rsel(input logic [7:0] a);
		case (a)
			`ALED_OFS_CTRL: rsel = RSEL_CTRL;
			`ALED_OFS_STAT: rsel = RSEL_STAT;
			`ALED_OFS_ISTS: rsel = RSEL_ISTS;
			default: rsel = RSEL_OTHER;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (rsel(a) != RSEL_OTHER) || (a == `ALED_OFS_ICLR) ||
			(a == `ALED_OFS_IEN);
	endfunction

	// first set bit at or after start, wrapping; start if none is set
	function automatic logic [1:0] pick(input logic [3:0] m,
		input logic [1:0] start);
		logic [1:0] r;
		logic [1:0] k;
		r = start;
		for (int i = 3; i >= 0; i--) begin
			k = start + 2'(i);
			if (m[k]) begin
				r = k;
			end
		end
		pick = r;
	endfunction

	// ----------------------------------------
	// sub blocks
	// ----------------------------------------
	aled_key_if #(.N(3)) kev ();
	logic fast_ph, slow_ph;

	aled_keys #(.N(3), .HOLD_CYC(HOLD_CYC)) u_keys (
		.clk(clk),
		.resetn(resetn),
		.keys_n({key_clear_n, key_next_n, key_info_n}),
		.ev(kev)
	);

	aled_flash #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) u_flash (
		.clk(clk),
		.resetn(resetn),
		.fast_ff(fast_ph),
		.slow_ff(slow_ph)
	);

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	logic [7:0] ctrl_ff;
	logic [3:0] ien_ff;
	logic ack_req, rbd;
	logic [3:0] cfg_mask;

	assign ack_req = ctrl_ff[`ALED_CTRL_ACKREQ];
	assign rbd = ctrl_ff[`ALED_CTRL_RBD];
	assign cfg_mask = ctrl_ff[`ALED_CTRL_CFG_LO +: 4];

	// ----------------------------------------
	// display state machine
	// ----------------------------------------
	aled_disp_t ds_ff, nxt_ds;
	logic [31:0] idle_ff, nxt_idle;
	logic [1:0] nxt_sel;
	logic nxt_err, ev_tmo, any_key;
	logic [3:0] act, ack_vec;

	assign act = alarm_in & cfg_mask;
	assign any_key = |kev.press;

	// opening, stepping, closing and idle timeout of the text list
	always_comb begin
		nxt_ds = ds_ff;
		nxt_sel = text_sel_ff;
		nxt_err = 1'b0;
		ev_tmo = 1'b0;
		ack_vec = 4'h0;
		nxt_idle = any_key ? 32'h0 : idle_ff + 32'h1;
		case (ds_ff)
			DS_CLOSED: begin
				nxt_idle = 32'h0;
				if (kev.short_rel[KEY_INFO]) begin
					if (cfg_mask == 4'h0) begin
						nxt_err = 1'b1;
					end else begin
						nxt_ds = DS_OPEN;
						// active alarms first, lowest index first
						nxt_sel = (act != 4'h0) ? pick(act, 2'h0) :
							pick(cfg_mask, 2'h0);
					end
				end
			end
			DS_OPEN: begin
				if (kev.short_rel[KEY_INFO]) begin
					nxt_ds = DS_CLOSED;
				end else if (kev.short_rel[KEY_NEXT]) begin
					// only configured functions form entries
					nxt_sel = pick(cfg_mask, text_sel_ff + 2'h1);
				end
				if (kev.hold[KEY_CLEAR] && ack_req) begin
					ack_vec[text_sel_ff] = 1'b1;
				end
				if (cfg_mask == 4'h0) begin
					nxt_ds = DS_CLOSED;
				end else if (!cfg_mask[text_sel_ff]) begin
					nxt_sel = pick(cfg_mask, text_sel_ff);
				end
				if (!any_key && idle_ff >= IDLE_CYC - 1) begin
					nxt_ds = DS_CLOSED;
					ev_tmo = 1'b1;
				end
			end
			default: begin
				nxt_ds = DS_CLOSED;
			end
		endcase
	end

	// display registers; text flag follows the selected alarm's state
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ds_ff <= DS_CLOSED;
			idle_ff <= 32'h0;
			text_sel_ff <= 2'h0;
			disp_open_ff <= 1'b0;
			text_active_ff <= 1'b0;
			disp_err_ff <= 1'b0;
		end else begin
			ds_ff <= nxt_ds;
			idle_ff <= nxt_idle;
			text_sel_ff <= nxt_sel;
			disp_open_ff <= (nxt_ds == DS_OPEN);
			text_active_ff <= act[nxt_sel];
			disp_err_ff <= nxt_err;
		end
	end

	// ----------------------------------------
	// alarm latches and indicators
	// ----------------------------------------
	logic [3:0] prev_ff, unack_ff, nxt_unack, nxt_led, nxt_rst;

	// set on a new activation wins over an acknowledgment in the same cycle
	always_comb begin
		nxt_unack = (act & ~prev_ff) | (unack_ff & ~ack_vec);
		if (!ack_req) begin
			nxt_unack = 4'h0;
		end
		nxt_unack = nxt_unack & cfg_mask;
		nxt_rst = rbd ? ack_vec : 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (!cfg_mask[i]) begin
				nxt_led[i] = 1'b0;
			end else if (!ack_req) begin
				nxt_led[i] = act[i];
			end else if (act[i]) begin
				nxt_led[i] = unack_ff[i] ? fast_ph : 1'b1;
			end else begin
				nxt_led[i] = unack_ff[i] & slow_ph;
			end
		end
	end

	// alarm registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			prev_ff <= 4'h0;
			unack_ff <= 4'h0;
			led_ff <= 4'h0;
			alarm_reset_ff <= 4'h0;
		end else begin
			prev_ff <= act;
			unack_ff <= nxt_unack;
			led_ff <= nxt_led;
			alarm_reset_ff <= nxt_rst;
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	logic [3:0] ists_ff, nxt_ists, ev, iclr;

	assign ev = {ev_tmo, nxt_err, |ack_vec, |(act & ~prev_ff)};

	// sticky bits, a new event beats a clear in the same cycle
	always_comb begin
		nxt_ists = ev | (ists_ff & ~iclr);
	end

	// status and interrupt line
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ists_ff <= 4'h0;
			irq_ff <= 1'b0;
		end else begin
			ists_ff <= nxt_ists;
			irq_ff <= |(nxt_ists & ien_ff);
		end
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
	logic [7:0] awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd;
	logic wl_ff, nxt_wl;
	logic nxt_bvalid, nxt_rvalid, nxt_awready, nxt_wready, nxt_arready;
	logic [1:0] nxt_bresp, nxt_rresp;
	logic [31:0] nxt_rdata, rd_word;
	logic [7:0] nxt_ctrl;
	logic [3:0] nxt_ien;
	logic do_wr;

	// address and data are taken in either order; write when both held
	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_w_got = w_got_ff;
		nxt_awa = awa_ff;
		nxt_wd = wd_ff;
		nxt_wl = wl_ff;
		nxt_bvalid = s_axi_bvalid;
		nxt_bresp = s_axi_bresp;
		nxt_ctrl = ctrl_ff;
		nxt_ien = ien_ff;
		iclr = 4'h0;
		do_wr = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_got = 1'b1;
			nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_got = 1'b1;
			nxt_wd = s_axi_wdata;
			nxt_wl = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (aw_got_ff && w_got_ff && !s_axi_bvalid) begin
			do_wr = 1'b1;
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = mapped(awa_ff) ? 2'h0 : 2'h3;
		end
		// only byte lane 0 carries writable fields
		if (do_wr && wl_ff) begin
			if (rsel(awa_ff) == RSEL_CTRL) begin
				nxt_ctrl = wd_ff[7:0];
			end
			if (awa_ff == `ALED_OFS_ICLR) begin
				iclr = wd_ff[3:0];
			end
			if (awa_ff == `ALED_OFS_IEN) begin
				nxt_ien = wd_ff[3:0];
			end
		end
		nxt_awready = !nxt_aw_got && !nxt_bvalid;
		nxt_wready = !nxt_w_got && !nxt_bvalid;
	end

	// read word for a decoded address; clear register reads zero
	always_comb begin
		case (rsel(s_axi_araddr))
			RSEL_CTRL: rd_word = {24'h0, ctrl_ff};
			RSEL_STAT: rd_word = {20'h0, text_active_ff, text_sel_ff,
				disp_open_ff, unack_ff, led_ff};
			RSEL_ISTS: rd_word = {28'h0, ists_ff};
			default: rd_word = (s_axi_araddr == `ALED_OFS_IEN) ?
				{28'h0, ien_ff} : 32'h0;
		endcase
		nxt_rvalid = s_axi_rvalid;
		nxt_rdata = s_axi_rdata;
		nxt_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = rd_word;
			nxt_rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h3;
		end
		nxt_arready = !nxt_rvalid;
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awa_ff <= 8'h0;
			wd_ff <= 32'h0;
			wl_ff <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
			ctrl_ff <= `ALED_CTRL_RST;
			ien_ff <= `ALED_IEN_RST;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			awa_ff <= nxt_awa;
			wd_ff <= nxt_wd;
			wl_ff <= nxt_wl;
			s_axi_awready <= nxt_awready;
			s_axi_wready <= nxt_wready;
			s_axi_bvalid <= nxt_bvalid;
			s_axi_bresp <= nxt_bresp;
			s_axi_arready <= nxt_arready;
			s_axi_rvalid <= nxt_rvalid;
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
			ctrl_ff <= nxt_ctrl;
			ien_ff <= nxt_ien;
		end
	end
endmodule
